// ---- rtl/dss_cfg.svh ----
// Purpose: offsets, field positions and reset values of the strobe generator
// Assumes: byte addressing on a 32-bit Avalon-MM slave
// Notes: definitions only
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define DSS_CTRL_OFFSET 4'h0
`define DSS_STATUS_OFFSET 4'h4

// ****************************************************************
// control fields
// ****************************************************************
`define DSS_SRC_LSB 0
`define DSS_SRC_MSB 1
`define DSS_RATIO_LSB 4
`define DSS_RATIO_MSB 7
`define DSS_ALIGN_BIT 8

// ****************************************************************
// status fields
// ****************************************************************
`define DSS_STAT_LOCK_BIT 0
`define DSS_STAT_ALIGNED_BIT 1
`define DSS_STAT_PLL_BIT 2
`define DSS_STAT_ARMED_BIT 3

// ****************************************************************
// reset values and limits
// ****************************************************************
`define DSS_SRC_RESET 2'h1
`define DSS_RATIO_RESET 4'h2
`define DSS_ALIGN_RESET 1'b1
`define DSS_RATIO_MIN 4'h1
`define DSS_RATIO_MAX 4'h8

`endif

// ---- rtl/dss_pkg.sv ----
// Purpose: types shared by the strobe generator files
// Assumes: nothing
// Notes: encodings of the lock source follow enum order
package dss_pkg;

    // lane coupling choice, order gives the control field code
    typedef enum logic [1:0] {
        DSS_INDEPENDENT,
        DSS_FOLLOW_LANE_ZERO,
        DSS_FOLLOW_LANE_ONE
    } dss_strobe_lock_source_e;

    // software configuration
    typedef struct packed {
        logic align_en;
        logic [3:0] ratio;
        dss_strobe_lock_source_e src;
    } dss_cfg_s;

    // observable state
    typedef struct packed {
        logic armed;
        logic pll_lock;
        logic aligned;
        logic lock_out;
    } dss_stat_s;

endpackage

// ---- rtl/dss_pin_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter and edge pulses
// Assumes: pin is asynchronous to clk_sys
// Notes: stage one feeds only stage two
`timescale 1ns/10ps

module dss_pin_sync
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // pin side
    input wire logic pin_in,
    // filtered side
    output logic level_reg,
    output logic rise_reg,
    output logic fall_reg
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic agree;

    // shift chain, stage one read by stage two only
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts once stages two and three agree
    assign agree = (s2_reg == s3_reg) && (s2_reg != level_reg);

    // filtered level and one-cycle edge pulses
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end
        else
        begin
            level_reg <= agree ? s2_reg : level_reg;
            rise_reg <= agree && s2_reg;
            fall_reg <= agree && !s2_reg;
        end
    end

endmodule // dss_pin_sync

// ---- rtl/dss_strobe_gen.sv ----
// Purpose: dual-lane serializer strobe generator with lane coupling and lock output
// Assumes: fast and reference clocks arrive as pins well below clk_sys / 6
// Notes: configuration over Avalon-MM, one wait state per access
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "dss_cfg.svh"

// Notes on behaviour
// - in independent mode each lane makes its own strobe from its own fast clock alone.
// - when following lane one, the lane-zero strobe repeats lane one's a fast cycle later.
// - when following lane zero, the lane-one strobe repeats lane zero's a fast cycle later.
// - the lock output stays low until the pll lock is high and alignment is done, then tracks it.
// - lock source takes independent, follow zero or follow one and resets to follow zero.
// - one ratio from 1 to 8, reset value 2, divides both fast clocks into strobes.
// - with align-to-reference set, as after reset, strobes are aligned to the reference clock.
// - strobe position is fixed on lock rising and again on each control write to byte 0, and kept by a free-running counter.
// - alignment is taken at a falling edge of the reference clock.
module dss_strobe_gen
    import dss_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // pll side pins
    input wire logic fast_clk_in_zero,
    input wire logic fast_clk_in_one,
    input wire logic slow_ref_clk,
    input wire logic pll_lock_in,
    // serializer side
    output logic fast_io_clk_zero,
    output logic fast_io_clk_one,
    output logic strobe_lane_zero,
    output logic strobe_lane_one,
    output logic strobe_lock_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // address decode, shared by read and write paths
    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] offs);
        reg_hit = (addr == offs);
    endfunction

    // true when the given lane copies the other lane's strobe
    function automatic logic is_slave(input dss_strobe_lock_source_e src, input int lane);
        is_slave = (lane == 0) ? (src == DSS_FOLLOW_LANE_ONE) : (src == DSS_FOLLOW_LANE_ZERO);
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************

    logic [3:0] pin_vec;
    logic [3:0] level_vec;
    logic [3:0] rise_vec;
    logic [3:0] fall_vec;

    // index 0/1 fast clocks, 2 reference clock, 3 pll lock
    assign pin_vec = {pll_lock_in, slow_ref_clk, fast_clk_in_one, fast_clk_in_zero};

    genvar gp;
    generate
        for (gp = 0; gp < 4; gp = gp + 1)
        begin : g_sync
            dss_pin_sync u_sync
            (
                .clk_sys(clk_sys),
                .reset(reset),
                .pin_in(pin_vec[gp]),
                .level_reg(level_vec[gp]),
                .rise_reg(rise_vec[gp]),
                .fall_reg(fall_vec[gp])
            );
        end
    endgenerate

    logic lock_level;
    logic lock_rise;
    logic slow_fall;
    logic [1:0] fast_edge;

    assign lock_level = level_vec[3];
    assign lock_rise = rise_vec[3];
    assign slow_fall = fall_vec[2];
    assign fast_edge = rise_vec[1:0];

    // fast clocks pass as synchronised, filtered copies, four clk_sys edges late
    assign fast_io_clk_zero = level_vec[0];
    assign fast_io_clk_one = level_vec[1];

    // ****************************************************************
    // register bus
    // ****************************************************************

    dss_cfg_s cfg_reg;
    dss_stat_s stat;
    logic wr_take;
    logic cfg_wr;
    logic [3:0] new_ratio;
    logic [1:0] new_src;

    assign wr_take = avs_write && !avs_waitrequest;
    assign cfg_wr = wr_take && reg_hit(avs_address, `DSS_CTRL_OFFSET) && avs_byteenable[0];
    assign new_ratio = avs_writedata[`DSS_RATIO_MSB:`DSS_RATIO_LSB];
    assign new_src = avs_writedata[`DSS_SRC_MSB:`DSS_SRC_LSB];

    // one wait state: request seen, then answered on the next edge
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    // read data prepared in the wait cycle, unmapped reads give zero
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
        begin
            avs_readdata <= 32'h0000_0000;
            if (reg_hit(avs_address, `DSS_CTRL_OFFSET))
            begin
                avs_readdata[`DSS_SRC_MSB:`DSS_SRC_LSB] <= cfg_reg.src;
                avs_readdata[`DSS_RATIO_MSB:`DSS_RATIO_LSB] <= cfg_reg.ratio;
                avs_readdata[`DSS_ALIGN_BIT] <= cfg_reg.align_en;
            end
            else if (reg_hit(avs_address, `DSS_STATUS_OFFSET))
                avs_readdata[3:0] <= stat;
        end
    end

    // configuration with reset defaults; illegal codes leave the field as is
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            cfg_reg.src <= dss_strobe_lock_source_e'(`DSS_SRC_RESET);
            cfg_reg.ratio <= `DSS_RATIO_RESET;
            cfg_reg.align_en <= `DSS_ALIGN_RESET;
        end
        else
        begin
            if (cfg_wr && (new_src <= 2'(DSS_FOLLOW_LANE_ONE)))
                cfg_reg.src <= dss_strobe_lock_source_e'(new_src);
            if (cfg_wr && (new_ratio >= `DSS_RATIO_MIN) && (new_ratio <= `DSS_RATIO_MAX))
                cfg_reg.ratio <= new_ratio;
            if (wr_take && reg_hit(avs_address, `DSS_CTRL_OFFSET) && avs_byteenable[1])
                cfg_reg.align_en <= avs_writedata[`DSS_ALIGN_BIT];
        end
    end

    // ****************************************************************
    // alignment
    // ****************************************************************

    logic armed_reg;
    logic aligned_reg;
    logic lock_out_reg;

    // arm once per lock rise; a config write re-arms so a new ratio is realigned
    always_ff @(posedge clk_sys)
    begin
        if (reset || !lock_level)
        begin
            armed_reg <= 1'b0;
            aligned_reg <= 1'b0;
        end
        else if (lock_rise || cfg_wr)
        begin
            armed_reg <= 1'b1;
            aligned_reg <= 1'b0;
        end
        // wait for a reference falling edge unless alignment is off
        else if (armed_reg && (slow_fall || !cfg_reg.align_en))
        begin
            armed_reg <= 1'b0;
            aligned_reg <= 1'b1;
        end
    end

    // lock output needs both pll lock and finished alignment
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            lock_out_reg <= 1'b0;
        else
            lock_out_reg <= aligned_reg && lock_level;
    end

    assign strobe_lock_out = lock_out_reg;
    assign stat = '{armed: armed_reg, pll_lock: lock_level, aligned: aligned_reg,
                    lock_out: lock_out_reg};

    // ****************************************************************
    // lane counters and strobes
    // ****************************************************************

    logic [2:0] ratio_m1;
    logic [2:0] cnt_reg [2];
    // unpacked so each lane's process owns its own element
    logic strobe_reg [2];

    assign ratio_m1 = 3'(cfg_reg.ratio - 4'h1);

    genvar gl;
    generate
        for (gl = 0; gl < 2; gl = gl + 1)
        begin : g_lane
            // free-running divider counter started at alignment
            always_ff @(posedge clk_sys)
            begin
                if (reset || !aligned_reg)
                    cnt_reg[gl] <= 3'h0;
                else if (fast_edge[gl])
                    cnt_reg[gl] <= (cnt_reg[gl] == ratio_m1) ? 3'h0 : 3'(cnt_reg[gl] + 3'h1);
            end

            // own count or the master's strobe one fast cycle late
            always_ff @(posedge clk_sys)
            begin
                if (reset || !aligned_reg)
                    strobe_reg[gl] <= 1'b0;
                else if (fast_edge[gl])
                    strobe_reg[gl] <= is_slave(cfg_reg.src, gl) ? strobe_reg[1 - gl]
                                                                : (cnt_reg[gl] == ratio_m1);
            end
        end
    endgenerate

    assign strobe_lane_zero = strobe_reg[0];
    assign strobe_lane_one = strobe_reg[1];

    // ****************************************************************
    // checks
    // ****************************************************************

    a_follow_one_delay: assert property (@(posedge clk_sys) disable iff (reset)
        (aligned_reg && cfg_reg.src == DSS_FOLLOW_LANE_ONE && fast_edge[0])
        |=> (strobe_reg[0] == $past(strobe_reg[1])))
        else $error("lane zero strobe does not trail lane one");

    a_follow_zero_delay: assert property (@(posedge clk_sys) disable iff (reset)
        (aligned_reg && cfg_reg.src == DSS_FOLLOW_LANE_ZERO && fast_edge[1])
        |=> (strobe_reg[1] == $past(strobe_reg[0])))
        else $error("lane one strobe does not trail lane zero");

    a_indep_own_count: assert property (@(posedge clk_sys) disable iff (reset)
        (aligned_reg && cfg_reg.src == DSS_INDEPENDENT && fast_edge[1] && !lock_rise && !cfg_wr)
        |=> (strobe_reg[1] == ($past(cnt_reg[1]) == $past(ratio_m1))))
        else $error("independent lane strobe not from its own counter");

    a_lock_needs_align: assert property (@(posedge clk_sys) disable iff (reset)
        lock_out_reg |-> ($past(aligned_reg) && $past(lock_level)))
        else $error("lock output high without alignment and pll lock");

    a_reset_defaults: assert property (@(posedge clk_sys)
        reset |=> (cfg_reg.src == DSS_FOLLOW_LANE_ZERO && cfg_reg.ratio == 4'h2
                   && cfg_reg.align_en))
        else $error("configuration defaults wrong after reset");

    a_ratio_range: assert property (@(posedge clk_sys) disable iff (reset)
        (cfg_reg.ratio >= 4'h1) && (cfg_reg.ratio <= 4'h8) && (cfg_reg.src != 2'h3))
        else $error("configuration outside legal range");

    a_align_at_fall: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(aligned_reg) |-> $past(slow_fall || !cfg_reg.align_en))
        else $error("alignment not taken at reference falling edge");

    a_counter_wrap: assert property (@(posedge clk_sys) disable iff (reset)
        (aligned_reg && lock_level && !cfg_wr && fast_edge[0] && cnt_reg[0] == ratio_m1)
        |=> (cnt_reg[0] == 3'h0))
        else $error("lane zero counter does not wrap at ratio");

    a_strobe_one_period: assert property (@(posedge clk_sys) disable iff (reset)
        (strobe_reg[0] && !fast_edge[0] && aligned_reg && lock_level && !cfg_wr)
        |=> strobe_reg[0])
        else $error("strobe dropped between fast edges");

    a_bus_one_wait: assert property (@(posedge clk_sys) disable iff (reset)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after exactly one wait state");

endmodule // dss_strobe_gen

// ---- dv/dss_pll_model.sv ----
// Purpose: pll model driving fast clocks, reference clock and lock
// Assumes: fast half period of four clk_sys cycles, slow enough to sample
// Notes: both fast clocks share one phase, as from a single pll
`timescale 1ns/10ps

module dss_pll_model
(
    // clock
    input wire logic clk_sys,
    // settings from bench
    input wire logic lock_req,
    input wire logic [3:0] ratio,
    // pll outputs
    output logic fast_zero,
    output logic fast_one,
    output logic ref_clk,
    output logic lock
);
    logic [2:0] ph_reg = 3'h0;
    logic [3:0] div_reg = 4'h0;

    // phase counter and divider; ratio 1 gives no reference edge, never used
    // ref at fast over ratio
    always @(posedge clk_sys)
    begin
        ph_reg <= ph_reg + 3'h1;
        if (ph_reg == 3'h3)
        begin
            div_reg <= (div_reg >= ratio - 4'h1) ? 4'h0 : div_reg + 4'h1;
        end
    end

    assign fast_zero = ph_reg[2];
    assign fast_one = ph_reg[2];
    assign ref_clk = (div_reg < (ratio >> 1));
    assign lock = lock_req;
endmodule // dss_pll_model

// ---- dv/test_dss_strobe_gen.sv ----
// Purpose: self-checking bench for the strobe generator
// Assumes: fast period of eight clk_sys cycles from the pll model
// Notes: strobe gaps and periods are counted in clk_sys cycles
`timescale 1ns/10ps

module test_dss_strobe_gen;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic fast0, fast1, ref_clk, pll_lock;
    logic io0, io1;
    logic strobe_lane_zero, strobe_lane_one, strobe_lock_out;
    logic lock_req = 1'b0;
    logic [3:0] ratio = 4'h2;
    logic [31:0] q;
    int n_errors = 0;
    int checks = 0;
    int g, p;

    dss_pll_model pll (.clk_sys(clk_sys), .lock_req(lock_req), .ratio(ratio),
        .fast_zero(fast0), .fast_one(fast1), .ref_clk(ref_clk), .lock(pll_lock));

    dss_strobe_gen dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fast_clk_in_zero(fast0),
        .fast_clk_in_one(fast1), .slow_ref_clk(ref_clk), .pll_lock_in(pll_lock),
        .fast_io_clk_zero(io0), .fast_io_clk_one(io1), .strobe_lane_zero(strobe_lane_zero),
        .strobe_lane_one(strobe_lane_one), .strobe_lock_out(strobe_lock_out));

    // 100 ns clock
    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end

    task chk32(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task chk_cnt(input string nm, input int e, input int s);
        checks++;
        if (s != e)
        begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one access held until waitrequest is seen low, then one idle edge
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50)
        begin
            n_errors++;
            $display("mismatch bus answer expected waitrequest low seen timeout");
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask

    // bounded wait for the lock output to reach a level
    task wait_lock(input logic lvl);
        int n;
        n = 0;
        while (strobe_lock_out !== lvl && n < 2000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk32("lock_out", {31'h0, lvl}, {31'h0, strobe_lock_out});
    endtask

    // cycles from a lead rise to the other lane's rise and the next lead rise
    task meas(input logic lead, output int gap, output int per);
        int t, ta, tb, tc;
        logic a, b, pa, pb;
        ta = -1;
        tb = -1;
        tc = -1;
        pa = 1'b1;
        pb = 1'b1;
        for (t = 0; t < 600 && tc < 0; t++)
        begin
            @(negedge clk_sys);
            a = lead ? strobe_lane_one : strobe_lane_zero;
            b = lead ? strobe_lane_zero : strobe_lane_one;
            if (a === 1'b1 && pa === 1'b0)
            begin
                if (ta < 0)
                    ta = t;
                else
                    tc = t;
            end
            if (b === 1'b1 && pb === 1'b0 && ta >= 0 && tb < 0)
                tb = t;
            pa = a;
            pb = b;
        end
        gap = tb - ta;
        per = tc - ta;
        @(posedge clk_sys);
    endtask

    // defaults, lock and follow lane zero at ratio 2
    task t_defaults;
        bus(1'b0, 4'h0, 32'h0);
        chk32("ctrl reset", 32'h0000_0121, q);
        bus(1'b0, 4'h4, 32'h0);
        chk32("status unlocked", 32'h0, q);
        bus(1'b0, 4'h8, 32'h0);
        chk32("unmapped", 32'h0, q);
        lock_req <= 1'b1;
        wait_lock(1'b1);
        bus(1'b0, 4'h4, 32'h0);
        chk32("status locked", 32'h0000_0007, q);
        meas(1'b0, g, p);
        chk_cnt("lane one lag", 8, g);
        chk_cnt("period r2", 16, p);
        $display("test defaults done");
    endtask

    // follow lane one at ratio 4, then refused codes
    task t_follow_one;
        ratio <= 4'h4;
        bus(1'b1, 4'h0, 32'h0000_0142);
        bus(1'b1, 4'h0, 32'h0000_0103);
        bus(1'b0, 4'h0, 32'h0);
        chk32("ctrl kept", 32'h0000_0142, q);
        wait_lock(1'b1);
        meas(1'b1, g, p);
        chk_cnt("lane zero lag", 8, g);
        chk_cnt("period r4", 32, p);
        $display("test follow one done");
    endtask

    // independent lanes from in-phase clocks rise together
    task t_indep;
        bus(1'b1, 4'h0, 32'h0000_0140);
        bus(1'b0, 4'h0, 32'h0);
        wait_lock(1'b1);
        meas(1'b0, g, p);
        chk_cnt("indep gap", 0, g);
        chk_cnt("indep period", 32, p);
        // fast clocks taken as from a global buffer, alignment off
        bus(1'b1, 4'h0, 32'h0000_0040);
        bus(1'b0, 4'h4, 32'h0);
        chk32("aligned at once", 32'h0000_0006, q);
        wait_lock(1'b1);
        $display("test independent done");
    endtask

    // fast io clocks are the pins seen four clk_sys edges later
    task t_io_clk;
        logic [3:0] h0, h1;
        int bad, t;
        h0 = 4'h0;
        h1 = 4'h0;
        bad = 0;
        for (t = 0; t < 40; t++)
        begin
            @(negedge clk_sys);
            if (t >= 4 && (io0 !== h0[3] || io1 !== h1[3]))
                bad++;
            h0 = {h0[2:0], fast0};
            h1 = {h1[2:0], fast1};
        end
        chk_cnt("io clock copy", 0, bad);
        @(posedge clk_sys);
        $display("test io clocks done");
    endtask

    // pll lock loss drops the lock output
    task t_drop;
        lock_req <= 1'b0;
        wait_lock(1'b0);
        bus(1'b0, 4'h4, 32'h0);
        chk32("status dropped", 32'h0, q & 32'h0000_0007);
        $display("test lock drop done");
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_defaults();
        t_io_clk();
        t_follow_one();
        t_indep();
        t_drop();
        finish_test();
    end

    // watchdog well beyond the expected few hundred cycles
    initial
    begin
        #(20000 * 100);
        n_errors++;
        finish_test();
    end
endmodule // test_dss_strobe_gen
